/* File: verilog/ifsdh_top.sv */
// Interframe deferral, receive blinding and heartbeat check
`timescale 1ns/1ps
module ifsdh_top #(
   parameter int unsigned CNT_W = ifsdh_pkg::CNT_W
) (
   // Clock, reset, enable
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   // Wire indications
   input wire ifsdh_pkg::ifsdh_wire_t WIRE_IN,
   // Transmit request, mode and heartbeat flag clear
   input wire logic TX_PENDING_IN,
   input wire logic TX_DONE_IN,
   input wire logic MODIFIED_BACKOFF_ENABLE_IN,
   input wire logic HB_FAIL_CLR_IN,
   // Transmit control
   output logic TRANSMIT_ACTIVE_OUT,
   output logic TX_START_OUT,
   // Receive gating and status
   output logic RX_ENABLE_OUT,
   output ifsdh_pkg::ifsdh_stat_t STAT_OUT
);
   // Refuse widths too narrow for the longest count
   if (CNT_W < 10 || CNT_W > 16) begin : g_bad_cnt_w
      $error("ifsdh_top: CNT_W must be 10 to 16");
   end

   // Count constants at the counter width
   localparam logic [CNT_W-1:0] P1 = CNT_W'(ifsdh_pkg::PART_ONE_CYC);
   localparam logic [CNT_W-1:0] P2 = CNT_W'(ifsdh_pkg::PART_TWO_CYC);
   localparam logic [CNT_W-1:0] TXB = CNT_W'(ifsdh_pkg::TX_BLIND_CYC);
   localparam logic [CNT_W-1:0] RXB = CNT_W'(ifsdh_pkg::RX_BLIND_CYC);
   localparam logic [CNT_W-1:0] HBW = CNT_W'(ifsdh_pkg::HB_WINDOW_CYC);
   localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

   // Deferral state and counter
   ifsdh_pkg::ifsdh_ifs_t st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   // Transmitting flag and collision seen in the current frame
   logic tx_r, tx_nxt;
   logic coll_r;
   // Heartbeat tracking
   logic hb_arm_r;
   logic hb_seen_r;
   logic hb_fail_r;
   // Previous carrier for edge detection
   logic crs_q_r;
   // Window and blinding timers
   logic hb_win;
   logic blind_tx;
   logic blind_rx;

   // Named decode wires
   wire crs = WIRE_IN.receive_carrier_active;
   wire col = WIRE_IN.collision;
   wire crs_fall = crs_q_r && !crs;
   wire tx_end = tx_r && TX_DONE_IN;
   wire blind = blind_tx || blind_rx;
   // Carrier during blinding is not counted as wire activity
   wire act = crs && !blind;
   wire hb_open = hb_arm_r && crs_fall;
   wire rx_end = crs_fall && !tx_r && !hb_arm_r && !blind;
   wire expire = (cnt_r == ONE);
   wire paused = MODIFIED_BACKOFF_ENABLE_IN && crs;
   wire start = (st_r == ifsdh_pkg::IFSDH_IDLE) && TX_PENDING_IN &&
                !tx_r && !act;

   // Deferral engine; part one counts only when the wire is clear, part two counts unless paused by modified backoff
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      tx_nxt = tx_r;
      if (tx_end) begin
         tx_nxt = 1'b0;
         st_nxt = ifsdh_pkg::IFSDH_PART1;
         cnt_nxt = P1;
      end else if (tx_r) begin
         tx_nxt = 1'b1;
      end else begin
         case (st_r)
            ifsdh_pkg::IFSDH_IDLE: begin
               if (act) begin
                  st_nxt = ifsdh_pkg::IFSDH_PART1;
                  cnt_nxt = P1;
               end else if (start) begin
                  tx_nxt = 1'b1;
               end
            end
            ifsdh_pkg::IFSDH_PART1: begin
               if (act) begin
                  cnt_nxt = P1;
               end else if (expire) begin
                  st_nxt = ifsdh_pkg::IFSDH_PART2;
                  cnt_nxt = P2;
               end else begin
                  cnt_nxt = cnt_r - ONE;
               end
            end
            ifsdh_pkg::IFSDH_PART2: begin
               if (paused) begin
                  cnt_nxt = cnt_r;
               end else if (expire) begin
                  // transmit at once or go idle
                  st_nxt = ifsdh_pkg::IFSDH_IDLE;
                  cnt_nxt = '0;
                  tx_nxt = TX_PENDING_IN;
               end else begin
                  cnt_nxt = cnt_r - ONE;
               end
            end
            default: begin
               st_nxt = ifsdh_pkg::IFSDH_IDLE;
            end
         endcase
      end
   end

   // Deferral registers
   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         st_r <= ifsdh_pkg::IFSDH_IDLE;
         cnt_r <= '0;
         tx_r <= 1'b0;
         crs_q_r <= 1'b0;
      end else if (CE_IN) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         tx_r <= tx_nxt;
         crs_q_r <= crs;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         coll_r <= 1'b0;
      end else if (CE_IN) begin
         if (!tx_r && tx_nxt)
            coll_r <= 1'b0;
         else if (tx_r && col)
            coll_r <= 1'b1;
      end
   end

   // arm the check at transmit end, skip after collision
   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         hb_arm_r <= 1'b0;
         hb_seen_r <= 1'b0;
      end else if (CE_IN) begin
         if (tx_end)
            hb_arm_r <= !(coll_r || col);
         else if (hb_open)
            hb_arm_r <= 1'b0;
         if (hb_open)
            hb_seen_r <= col;
         else if (hb_win && col)
            hb_seen_r <= 1'b1;
      end
   end

   // flag on missed heartbeat; set wins over clear
   logic hb_win_q_r;
   wire hb_win_end = hb_win_q_r && !hb_win;
   wire hb_miss = hb_win_end && !hb_seen_r && !col;
   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         hb_fail_r <= 1'b0;
         hb_win_q_r <= 1'b0;
      end else if (CE_IN) begin
         hb_win_q_r <= hb_win;
         if (hb_miss)
            hb_fail_r <= 1'b1;
         else if (HB_FAIL_CLR_IN)
            hb_fail_r <= 1'b0;
      end
   end

   // window opens at carrier drop, 4us long
   ifsdh_timer #(.W(CNT_W)) u_hb_win (
      .clk(CORE_CLK_IN),
      .nrst(NRST_IN),
      .ce(CE_IN),
      .load(hb_open),
      .value(HBW),
      .busy(hb_win)
   );

   ifsdh_timer #(.W(CNT_W)) u_tx_blind (
      .clk(CORE_CLK_IN),
      .nrst(NRST_IN),
      .ce(CE_IN),
      .load(tx_end),
      .value(TXB),
      .busy(blind_tx)
   );

   // short blind after reception; self-ending timer
   ifsdh_timer #(.W(CNT_W)) u_rx_blind (
      .clk(CORE_CLK_IN),
      .nrst(NRST_IN),
      .ce(CE_IN),
      .load(rx_end),
      .value(RXB),
      .busy(blind_rx)
   );

   // Outputs
   assign TRANSMIT_ACTIVE_OUT = tx_r;
   assign TX_START_OUT = !tx_r && tx_nxt && CE_IN;
   assign RX_ENABLE_OUT = !blind && !tx_r;
   assign STAT_OUT.heartbeat_fail_flag = hb_fail_r;
   assign STAT_OUT.rx_blind = blind;
   assign STAT_OUT.ifs_busy = (st_r != ifsdh_pkg::IFSDH_IDLE);
   assign STAT_OUT.hb_window = hb_win;

   // part two never reloads part one
   a_part_two_hold: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (st_r == ifsdh_pkg::IFSDH_PART2 && CE_IN && !tx_r)
      |=> st_r != ifsdh_pkg::IFSDH_PART1)
      else $error("part two returned to part one");
   a_part_one_reset: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (st_r == ifsdh_pkg::IFSDH_PART1 && act && CE_IN && !tx_r)
      |=> cnt_r == P1)
      else $error("part one not restarted");
   a_expiry_start: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (st_r == ifsdh_pkg::IFSDH_PART2 && expire && !paused && CE_IN
       && TX_PENDING_IN && !tx_r) |=> tx_r)
      else $error("no start at expiry");
   a_tx_defer: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (tx_end && CE_IN) |=> st_r == ifsdh_pkg::IFSDH_PART1
      && cnt_r == P1)
      else $error("no deferral after transmit");
   a_tx_blind: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (tx_end && CE_IN) |=> !RX_ENABLE_OUT)
      else $error("receiver not blinded");
   a_hb_open: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (hb_open && CE_IN) |=> hb_win)
      else $error("window did not open");
   a_coll_nofail: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (tx_end && CE_IN && (coll_r || col)) |=> !hb_arm_r)
      else $error("check armed after collision");
   a_hb_flag: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (hb_miss && CE_IN) |=> hb_fail_r)
      else $error("flag not set");
   a_backoff_pause: assert property (@(posedge CORE_CLK_IN)
      disable iff (!NRST_IN)
      (st_r == ifsdh_pkg::IFSDH_PART2 && paused && CE_IN && !tx_r)
      |=> $stable(cnt_r))
      else $error("count moved under carrier");

   c_tx_start: cover property (@(posedge CORE_CLK_IN) TX_START_OUT);
   c_hb_fail: cover property (@(posedge CORE_CLK_IN) hb_miss);
   c_part_two: cover property (@(posedge CORE_CLK_IN)
      st_r == ifsdh_pkg::IFSDH_PART2);
endmodule

/* File: verilog/ifsdh_pkg.sv */
// Package of timing constants, states and carriers for the deferral block
package ifsdh_pkg;
   // Clock period in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 10000;
   // Interval lengths in nanoseconds
   localparam int unsigned PART_ONE_NS = 6000;
   localparam int unsigned PART_TWO_NS = 3600;
   localparam int unsigned TX_BLIND_NS = 4000;
   localparam int unsigned RX_BLIND_MAX_NS = 500;
   localparam int unsigned HB_WINDOW_NS = 4000;
   // Least times round up, longest times round down
   localparam int unsigned PART_ONE_CYC =
      (PART_ONE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PART_TWO_CYC =
      (PART_TWO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TX_BLIND_CYC =
      (TX_BLIND_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Strictly under 500 ns, so one cycle less than the floor
   localparam int unsigned RX_BLIND_CYC =
      (RX_BLIND_MAX_NS * 1000) / CLK_PERIOD_PS - 1;
   localparam int unsigned HB_WINDOW_CYC =
      (HB_WINDOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Counter width serving every count above
   localparam int unsigned CNT_W = 10;
   // Heartbeat flag position in the primary status register
   localparam int unsigned HB_FAIL_BIT = 13;
   // Modified backoff enable position in the mode setting
   localparam int unsigned MOD_BACKOFF_BIT = 7;

   // Interframe deferral states
   typedef enum logic [1:0] {
      IFSDH_IDLE,
      IFSDH_PART1,
      IFSDH_PART2
   } ifsdh_ifs_t;

   // Wire indications from the attachment side
   typedef struct packed {
      logic receive_carrier_active;
      logic collision;
   } ifsdh_wire_t;

   // Status toward the rest of the controller
   typedef struct packed {
      logic heartbeat_fail_flag;
      logic rx_blind;
      logic ifs_busy;
      logic hb_window;
   } ifsdh_stat_t;
endpackage

/* File: verilog/ifsdh_timer.sv */
// Loadable down-counter used for the blinding and heartbeat intervals
`timescale 1ns/1ps
module ifsdh_timer #(
   parameter int unsigned W = 10
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic busy
);
   // Remaining cycles
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // Load wins over counting; stop at zero
   assign cnt_nxt = load ? value :
                    (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
   assign busy = (cnt_r != '0);

   // Counter state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

/* File: test/ifsdh_mau_model.sv */
// Attachment unit model: carrier echo, heartbeat and received bursts
`timescale 1ns/1ps
module ifsdh_mau_model (
   // Clock
   input wire logic clk_in,
   // Controller side
   input wire logic transmit_active_in,
   // Wire indications toward the controller
   output ifsdh_pkg::ifsdh_wire_t wire_out
);
   // Heartbeat on by default; the bench turns it off to fake a fault
   logic hb_on = 1'b1;
   // Collision forced during a frame
   logic coll_req = 1'b0;
   // Received frame carrier
   logic rx_car = 1'b0;
   // Cycles since transmit end, parked high so no heartbeat at start
   int since = 1000;
   logic car;
   logic col;

   // Count from the end of own transmission
   always @(negedge clk_in) begin
      if (transmit_active_in === 1'b1) begin
         since <= 0;
      end else if (since < 1000) begin
         since <= since + 1;
      end
   end

   // Carrier echoes the frame and lingers a few cycles
   assign car = rx_car | (transmit_active_in === 1'b1) | (since < 3);
   // heartbeat after every frame while hb_on is set
   // Pulse 0.8 us after frame end, also after collided frames
   assign col = coll_req | (hb_on && since >= 80 && since < 90);
   assign wire_out = {car, col};

   // Carrier burst of n cycles, returns at carrier drop
   task automatic recv(input int n);
      rx_car = 1'b1;
      repeat (n) @(negedge clk_in);
      rx_car = 1'b0;
   endtask

   // Short collision burst
   task automatic collide();
      coll_req = 1'b1;
      repeat (5) @(negedge clk_in);
      coll_req = 1'b0;
   endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for deferral, blinding and heartbeat check
`timescale 1ns/1ps
module tb_top;
   // Drives, all changed at falling edges
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic pend = 1'b0;
   logic done = 1'b0;
   logic mbo = 1'b0;
   logic clr = 1'b0;
   logic ce = 1'b1;
   // Start strobe as it stood just before the last rising edge
   logic start_q = 1'b0;
   // Design outputs and wire
   ifsdh_pkg::ifsdh_wire_t wire_s;
   logic act;
   logic start;
   logic rxen;
   ifsdh_pkg::ifsdh_stat_t st;
   // Scoreboard
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int seed = 32'hab5acee0;
   int r;
   int exp_q[$];
   logic flag_q[$];
   localparam int GAP = 960;

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) start_q <= start;

   ifsdh_top dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
      .WIRE_IN(wire_s), .TX_PENDING_IN(pend), .TX_DONE_IN(done),
      .MODIFIED_BACKOFF_ENABLE_IN(mbo), .HB_FAIL_CLR_IN(clr),
      .TRANSMIT_ACTIVE_OUT(act), .TX_START_OUT(start),
      .RX_ENABLE_OUT(rxen), .STAT_OUT(st));
   ifsdh_mau_model mau (.clk_in(clk), .transmit_active_in(act),
      .wire_out(wire_s));

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Start moment against the oldest note, from one cycle early to two cycles late
   initial forever begin
      @(posedge act);
      @(negedge clk);
      if (exp_q.size() > 0) begin
         r = exp_q.pop_front();
         chk("start cycle", cyc >= r - 1 && cyc <= r + 2, 1);
      end
      chk("tx start", start_q, 1);
   end

   // Flag just after the heartbeat window closes
   initial forever begin
      @(negedge st.hb_window);
      repeat (2) @(negedge clk);
      if (flag_q.size() > 0) begin
         chk("hb flag", st.heartbeat_fail_flag, flag_q.pop_front());
      end
   end

   // One frame: wait start, random length, optional collision
   task automatic frame(input logic coll, input logic hb, output int t);
      int i;
      mau.hb_on = hb;
      if (!coll) flag_q.push_back(!hb);
      for (i = 0; i < 3000 && act !== 1'b1; i++) @(negedge clk);
      repeat (20 + ($unsigned($random(seed)) % 64)) @(negedge clk);
      if (coll) mau.collide();
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      for (i = 0; i < 10 && act === 1'b1; i++) @(negedge clk);
      t = cyc;
   endtask

   // Count blinded cycles over a span
   task automatic low_count(input int span, output int n);
      n = 0;
      repeat (span) begin
         @(negedge clk);
         if (rxen === 1'b0) n++;
      end
   endtask

   // Receive, then a burst at gap_at cycles into the deferral
   task automatic rx_case(input int gap_at, input logic bo);
      int f;
      int n;
      int len;
      mbo = bo;
      len = 50;
      mau.recv(50 + ($unsigned($random(seed)) % 150));
      f = cyc;
      pend = 1'b1;
      low_count(gap_at, n);
      chk("rx blind", n > 0 && n < 50, 1);
      mau.recv(len);
      if (gap_at < 600) exp_q.push_back(cyc + GAP);
      else if (bo) exp_q.push_back(f + GAP + len);
      else exp_q.push_back(f + GAP);
      frame(1'b0, 1'b1, f);
      pend = 1'b0;
      repeat (1200) @(negedge clk);
   endtask

   // Main sequence
   initial begin
      int t;
      int n;
      repeat (3) @(negedge clk);
      chk("reset act", act, 0);
      chk("reset rxen", rxen, 1);
      chk("reset stat", st, 0);
      nrst = 1'b1;
      @(negedge clk);
      // Idle wire: start at once, then back to back with deferral
      pend = 1'b1;
      exp_q.push_back(cyc + 1);
      frame(1'b0, 1'b1, t);
      exp_q.push_back(t + GAP + 10);
      low_count(500, n);
      chk("tx blind", n >= 398 && n <= 402, 1);
      chk("blind end", st.rx_blind, 0);
      chk("ifs busy", st.ifs_busy, 1);
      // Freeze the deferral for ten cycles, start moves by ten
      ce = 1'b0;
      repeat (10) @(negedge clk);
      ce = 1'b1;
      // Second frame with heartbeat missing
      frame(1'b0, 1'b0, t);
      pend = 1'b0;
      repeat (700) @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      repeat (3) @(negedge clk);
      chk("hb clear", st.heartbeat_fail_flag, 0);
      // Collided frame, no heartbeat, no failure
      // Raised during part two, so it leaves at expiry
      pend = 1'b1;
      exp_q.push_back(t + GAP);
      frame(1'b1, 1'b0, t);
      pend = 1'b0;
      repeat (700) @(negedge clk);
      chk("coll no check", st.heartbeat_fail_flag, 0);
      mau.hb_on = 1'b1;
      repeat (500) @(negedge clk);
      // Activity in part one, part two, part two with pause
      rx_case(300, 1'b0);
      rx_case(700, 1'b0);
      rx_case(700, 1'b1);
      chk("queue empty", exp_q.size() + flag_q.size(), 0);
      finish_test();
   end

   // Watchdog well past the expected run
   initial begin
      #500000;
      n_errors++;
      finish_test();
   end
endmodule
